// ---- hw/pmic_channel_mode_status_regs.svh ----
// Constants for the channel mode and status register bank.
// Assumes a 32-bit bus with one register per aligned word.
`ifndef PMIC_CHANNEL_MODE_STATUS_REGS_SVH
`define PMIC_CHANNEL_MODE_STATUS_REGS_SVH
`define OVERVOLTAGE_FLAGS_IDX       8'h1b
`define SWITCHING_MODE_SELECT_IDX   8'h1c
`define POWER_CONTROL_SOURCE_IDX    8'h1d
`define CH6_REGULATION_CONFIG_IDX   8'h1e
`define SLEW_RATE_REDUCE_IDX        8'h1f
`define IRQ_MASK_IDX                8'h28
`define OV_FIELD_W                  6
`define SEQ_FIELD_W                 7
`define CH6_STEP_DOWN_ONLY_POS      4
`define SLEW_RATE_REDUCE_RST        6'h00
`define IRQ_MASK_RST                6'h00
`endif

// ---- hw/pmic_channel_mode_status_pkg.sv ----
// Types for the channel mode and status register bank.
// Assumes the constants header is included by the design file.
package pmic_channel_mode_status_pkg;
  typedef enum logic [1:0] {
    TH_RATIO_082,
    TH_RATIO_079,
    TH_RATIO_077,
    TH_RATIO_085
  } step_up_threshold_t;
endpackage : pmic_channel_mode_status_pkg

// ---- hw/pmic_channel_mode_status_regs.sv ----
// Channel mode and overvoltage status register bank, AHB-Lite slave.
// Assumes fuse defaults are stable from reset release until the first
// clock edge with hclk_en high, and overvoltage events are synchronous.
//
// Overview of operation
// [RULE_01] Per-channel overvoltage flags set on detection.
// [RULE_02] Writing one clears only that flag.
// [RULE_03] Overvoltage flags read zero after reset.
// [RULE_04] Mode bit: 0 forced PWM, 1 auto.
// [RULE_05] Mode registers load fuse defaults at power-up.
// [RULE_06] Control bit: 0 manual, 1 sequencer.
// [RULE_07] Bit 4 selects buck-only for channel 6.
// [RULE_08] Two-bit code selects boost threshold ratio.
// [RULE_09] Threshold ignored while buck-only is selected.
// [RULE_10] Slew-rate register resets to zero always.
// [RULE_11] Slew bit one reduces channel slew rate.
// [RULE_12] Discontinuous option needs channels 5, 6 auto.
// [RULE_13] Unassigned bits read zero, ignore writes.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "pmic_channel_mode_status_regs.svh"
module pmic_channel_mode_status_regs
  import pmic_channel_mode_status_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hclk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [5:0]  overvolt_detect,
  input  wire logic [5:0]  fuse_switching_mode,
  input  wire logic [6:0]  fuse_control_source,
  input  wire logic [7:0]  fuse_ch6_config,
  input  wire logic        discontinuous_request,
  output logic      [5:0]  ch_auto_skip_enable,
  output logic      [6:0]  ch_sequencer_select,
  output logic             ch6_step_down_only,
  output logic             ch6_boost_active,
  output step_up_threshold_t ch6_step_up_threshold,
  output logic      [5:0]  ch_slow_edges,
  output logic             ch5_ch6_discontinuous_enable,
  output logic             irq
);

  logic [5:0]  ov_flags_ff;
  logic [5:0]  mode_ff;
  logic [6:0]  seq_ff;
  logic        down_only_ff;
  logic [1:0]  thr_ff;
  logic [5:0]  slew_ff;
  logic [5:0]  irq_mask_ff;
  logic        fuse_loaded_ff;
  logic        wr_pend_ff;
  logic [7:0]  addr_ff;
  logic [31:0] rdata_ff;
  logic        irq_ff;
  logic        dcm_ff;
  logic        ch6_boost_ff;
  logic        addr_phase;
  logic        wr_go;
  logic [5:0]  nxt_ov_flags;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a == idx);
  endfunction : hit

  // Only six words are backed by storage; every other index reads zero.
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = hit(a, `OVERVOLTAGE_FLAGS_IDX) ||
                hit(a, `SWITCHING_MODE_SELECT_IDX) ||
                hit(a, `POWER_CONTROL_SOURCE_IDX) ||
                hit(a, `CH6_REGULATION_CONFIG_IDX) ||
                hit(a, `SLEW_RATE_REDUCE_IDX) ||
                hit(a, `IRQ_MASK_IDX);
  endfunction : is_mapped

  // Word index is the byte address divided by four.
  assign addr_phase = hsel && hready && htrans[1] && hclk_en;
  assign wr_go      = wr_pend_ff && hclk_en;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      addr_ff    <= 8'h00;
    end
    else if (hclk_en)
    begin
      wr_pend_ff <= addr_phase && hwrite;
      if (addr_phase)
        addr_ff <= haddr[9:2];
    end
  end

  // Zero wait states: the slave never stretches a transfer.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // A new event wins over a clear in the same cycle.
  always_comb
  begin
    nxt_ov_flags = ov_flags_ff;
    if (wr_go && hit(addr_ff, `OVERVOLTAGE_FLAGS_IDX))
      nxt_ov_flags = nxt_ov_flags & ~hwdata[5:0]; // [RULE_02]
    nxt_ov_flags = nxt_ov_flags | overvolt_detect; // [RULE_01]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ov_flags_ff <= 6'h00; // [RULE_03]
    else if (hclk_en)
      ov_flags_ff <= nxt_ov_flags;
  end

  // Fuse values are captured on the first enabled edge after reset, since
  // an asynchronous reset may only load constants.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fuse_loaded_ff <= 1'b0;
      mode_ff        <= 6'h00;
      seq_ff         <= 7'h00;
      down_only_ff   <= 1'b0;
      thr_ff         <= 2'h0;
    end
    else if (hclk_en)
    begin
      fuse_loaded_ff <= 1'b1;
      if (!fuse_loaded_ff)
      begin
        mode_ff      <= fuse_switching_mode; // [RULE_05]
        seq_ff       <= fuse_control_source; // [RULE_05]
        down_only_ff <= fuse_ch6_config[`CH6_STEP_DOWN_ONLY_POS]; // [RULE_05]
        thr_ff       <= fuse_ch6_config[1:0]; // [RULE_05]
      end
      else if (wr_go)
      begin
        if (hit(addr_ff, `SWITCHING_MODE_SELECT_IDX))
          mode_ff <= hwdata[5:0]; // [RULE_04]
        if (hit(addr_ff, `POWER_CONTROL_SOURCE_IDX))
          seq_ff <= hwdata[6:0]; // [RULE_06]
        if (hit(addr_ff, `CH6_REGULATION_CONFIG_IDX))
        begin
          down_only_ff <= hwdata[`CH6_STEP_DOWN_ONLY_POS]; // [RULE_07]
          thr_ff       <= hwdata[1:0]; // [RULE_08]
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      slew_ff     <= `SLEW_RATE_REDUCE_RST; // [RULE_10]
      irq_mask_ff <= `IRQ_MASK_RST;
    end
    else if (wr_go && fuse_loaded_ff)
    begin
      if (hit(addr_ff, `SLEW_RATE_REDUCE_IDX))
        slew_ff <= hwdata[5:0]; // [RULE_11]
      if (hit(addr_ff, `IRQ_MASK_IDX))
        irq_mask_ff <= hwdata[5:0];
    end
  end

  // Unmapped words and upper bits read zero. [RULE_13]
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_ff <= 32'h0000_0000;
    else if (addr_phase && !hwrite)
    begin
      case (haddr[9:2])
        `OVERVOLTAGE_FLAGS_IDX:     rdata_ff <= {26'h0, ov_flags_ff};
        `SWITCHING_MODE_SELECT_IDX: rdata_ff <= {26'h0, mode_ff};
        `POWER_CONTROL_SOURCE_IDX:  rdata_ff <= {25'h0, seq_ff};
        `CH6_REGULATION_CONFIG_IDX:
          rdata_ff <= {27'h0, down_only_ff, 2'h0, thr_ff};
        `SLEW_RATE_REDUCE_IDX:      rdata_ff <= {26'h0, slew_ff};
        `IRQ_MASK_IDX:              rdata_ff <= {26'h0, irq_mask_ff};
        default:                    rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // The discontinuous option is forced off unless both channels run auto.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dcm_ff       <= 1'b0;
      ch6_boost_ff <= 1'b0;
      irq_ff       <= 1'b0;
    end
    else if (hclk_en)
    begin
      dcm_ff       <= discontinuous_request && mode_ff[4]
                      && mode_ff[5]; // [RULE_12]
      ch6_boost_ff <= !down_only_ff; // [RULE_09]
      irq_ff       <= |(nxt_ov_flags & irq_mask_ff);
    end
  end

  assign hrdata                       = rdata_ff;
  assign ch_auto_skip_enable          = mode_ff;
  assign ch_sequencer_select          = seq_ff;
  assign ch6_step_down_only           = down_only_ff;
  assign ch6_boost_active             = ch6_boost_ff;
  assign ch6_step_up_threshold        = step_up_threshold_t'(thr_ff);
  assign ch_slow_edges                = slew_ff;
  assign ch5_ch6_discontinuous_enable = dcm_ff;
  assign irq                          = irq_ff;

  a_ov_set_sticks: assert property ( // [RULE_01]
    @(posedge hclk) disable iff (!hresetn)
    hclk_en && overvolt_detect[0] |=> ov_flags_ff[0])
    else $error("Overvoltage event did not set its flag.");

  a_ov_clear_one: assert property ( // [RULE_02]
    @(posedge hclk) disable iff (!hresetn)
    wr_go && hit(addr_ff, `OVERVOLTAGE_FLAGS_IDX)
    |=> (ov_flags_ff & $past(hwdata[5:0] & ~overvolt_detect)) == 6'h00)
    else $error("Flag survived a write of one.");

  a_ov_keep_zero: assert property ( // [RULE_02]
    @(posedge hclk) disable iff (!hresetn)
    wr_go && ov_flags_ff != 6'h00
    |=> (ov_flags_ff & $past(ov_flags_ff & ~hwdata[5:0]))
        == $past(ov_flags_ff & ~hwdata[5:0]))
    else $error("Flag lost on a write of zero.");

  a_ov_reset_zero: assert property ( // [RULE_03]
    @(posedge hclk)
    !hresetn |-> ov_flags_ff == 6'h00)
    else $error("Flags not zero in reset.");

  a_mode_write: assert property ( // [RULE_04]
    @(posedge hclk) disable iff (!hresetn)
    wr_go && fuse_loaded_ff && hit(addr_ff, `SWITCHING_MODE_SELECT_IDX)
    |=> ch_auto_skip_enable == $past(hwdata[5:0]))
    else $error("Mode write not applied.");

  a_fuse_load: assert property ( // [RULE_05]
    @(posedge hclk) disable iff (!hresetn)
    hclk_en && !fuse_loaded_ff |=> seq_ff == $past(fuse_control_source)
    && mode_ff == $past(fuse_switching_mode))
    else $error("Fuse defaults not loaded.");

  a_seq_write: assert property ( // [RULE_06]
    @(posedge hclk) disable iff (!hresetn)
    wr_go && fuse_loaded_ff && hit(addr_ff, `POWER_CONTROL_SOURCE_IDX)
    |=> ch_sequencer_select == $past(hwdata[6:0]))
    else $error("Control source write not applied.");

  a_ch6_write: assert property ( // [RULE_07] [RULE_08]
    @(posedge hclk) disable iff (!hresetn)
    wr_go && fuse_loaded_ff && hit(addr_ff, `CH6_REGULATION_CONFIG_IDX)
    |=> ch6_step_up_threshold == $past(hwdata[1:0])
        && ch6_step_down_only == $past(hwdata[`CH6_STEP_DOWN_ONLY_POS]))
    else $error("Channel 6 configuration write not applied.");

  a_boost_gate: assert property ( // [RULE_09]
    @(posedge hclk) disable iff (!hresetn)
    hclk_en && down_only_ff |=> !ch6_boost_active)
    else $error("Boost active in buck-only mode.");

  a_slew_write: assert property ( // [RULE_11]
    @(posedge hclk) disable iff (!hresetn)
    wr_go && fuse_loaded_ff && hit(addr_ff, `SLEW_RATE_REDUCE_IDX)
    |=> ch_slow_edges == $past(hwdata[5:0]))
    else $error("Slew write not applied.");

  a_dcm_guard: assert property ( // [RULE_12]
    @(posedge hclk) disable iff (!hresetn)
    hclk_en && !(mode_ff[4] && mode_ff[5])
    |=> !ch5_ch6_discontinuous_enable)
    else $error("Discontinuous mode without auto on both.");

  a_unmapped_zero: assert property ( // [RULE_13]
    @(posedge hclk) disable iff (!hresetn)
    addr_phase && !hwrite && !is_mapped(haddr[9:2])
    |=> hrdata == 32'h0000_0000)
    else $error("Unmapped read not zero.");

  a_enable_freeze: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !hclk_en |=> $stable(ov_flags_ff) && $stable(mode_ff)
    && $stable(slew_ff) && $stable(rdata_ff))
    else $error("State moved while the clock enable was low.");

  a_irq_level: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $stable(irq_mask_ff) |-> irq == |(ov_flags_ff & irq_mask_ff))
    else $error("Interrupt does not follow the unmasked flags.");

  c_ov_clear: cover property (@(posedge hclk)
    wr_go && hit(addr_ff, `OVERVOLTAGE_FLAGS_IDX));
  c_set_beats_clear: cover property (@(posedge hclk)
    wr_go && hit(addr_ff, `OVERVOLTAGE_FLAGS_IDX)
    && |(hwdata[5:0] & overvolt_detect));
  c_irq_raise: cover property (@(posedge hclk) $rose(irq));
  c_dcm_on: cover property (@(posedge hclk) $rose(dcm_ff));

endmodule : pmic_channel_mode_status_regs

// ---- test/pmic_channel_mode_status_regs_tb.sv ----
// Self-checking bench for the channel mode and status register bank.
// Assumes one AHB-Lite slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module pmic_channel_mode_status_regs_tb
  import pmic_channel_mode_status_pkg::*;
;
  typedef struct packed
  {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_t;
  logic               hclk, hresetn, hclk_en, hsel, hwrite, hready;
  logic               hreadyout, hresp, discontinuous_request;
  logic               ch6_step_down_only, ch6_boost_active, irq;
  logic               ch5_ch6_discontinuous_enable;
  logic [31:0]        haddr, hwdata, hrdata, rd_v;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [5:0]         overvolt_detect, fuse_switching_mode;
  logic [5:0]         ch_auto_skip_enable, ch_slow_edges;
  logic [6:0]         fuse_control_source, ch_sequencer_select;
  logic [7:0]         fuse_ch6_config;
  step_up_threshold_t ch6_step_up_threshold;
  int                 n_fail, n_checks;
  row_t rows [9] = '{'{32'h70, 32'hffffffff, 32'h3f},
    '{32'h74, 32'hffffffff, 32'h7f}, '{32'h78, 32'hffffffff, 32'h13},
    '{32'h7c, 32'hffffffff, 32'h3f}, '{32'ha0, 32'hffffffff, 32'h3f},
    '{32'h40, 32'hffffffff, 32'h00}, '{32'ha0, 32'h00000000, 32'h00},
    '{32'h6c, 32'h00000000, 32'h00}, '{32'h74, 32'h0000002a, 32'h2a}};
  assign hready = hreadyout;
  pmic_channel_mode_status_regs dut (.hclk, .hresetn, .hclk_en, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .overvolt_detect, .fuse_switching_mode,
    .fuse_control_source, .fuse_ch6_config, .discontinuous_request,
    .ch_auto_skip_enable, .ch_sequencer_select, .ch6_step_down_only,
    .ch6_boost_active, .ch6_step_up_threshold, .ch_slow_edges,
    .ch5_ch6_discontinuous_enable, .irq);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // The slave never stretches a phase, yet both waits still poll hready.
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd_v = hrdata;
  endtask : xfer
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : tick
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial
  begin
    #100000;
    n_fail++;
    wrap_up();
  end
  initial
  begin
    hresetn = 1'b0;
    hclk_en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    overvolt_detect = 6'h00;
    fuse_switching_mode = 6'h35;
    fuse_control_source = 7'h5a;
    fuse_ch6_config = 8'hff;
    discontinuous_request = 1'b1;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    tick(2);
    chk(ch_auto_skip_enable, 32'h35);
    chk(ch_sequencer_select, 32'h5a);
    chk({ch6_step_down_only, ch6_step_up_threshold}, 32'h7);
    xfer(1'b0, 32'h6c, 32'h0);
    chk(rd_v, 32'h0);
    xfer(1'b0, 32'h7c, 32'h0);
    chk(rd_v, 32'h0);
    chk({hreadyout, hresp}, 32'h2);
    foreach (rows[i])
    begin
      xfer(1'b1, rows[i].a, rows[i].d);
      xfer(1'b0, rows[i].a, 32'h0);
      chk(rd_v, rows[i].e);
    end
    // Every threshold code is tried in both regulation modes.
    for (int c = 0; c < 8; c++)
    begin
      xfer(1'b1, 32'h78, {27'h0, c[2], 2'b00, c[1:0]});
      tick(1);
      chk({ch6_step_down_only, ch6_boost_active, ch6_step_up_threshold},
          {28'h0, c[2], ~c[2], c[1:0]});
    end
    xfer(1'b1, 32'h7c, 32'h2a);
    tick(1);
    chk(ch_slow_edges, 32'h2a);
    xfer(1'b1, 32'h70, 32'h30);
    tick(1);
    chk(ch5_ch6_discontinuous_enable, 32'h1);
    xfer(1'b1, 32'h70, 32'h10);
    tick(1);
    chk(ch5_ch6_discontinuous_enable, 32'h0);
    overvolt_detect <= 6'h21;
    @(posedge hclk);
    overvolt_detect <= 6'h00;
    xfer(1'b0, 32'h6c, 32'h0);
    chk(rd_v, 32'h21);
    chk(irq, 32'h0);
    xfer(1'b1, 32'ha0, 32'h20);
    tick(2);
    chk(irq, 32'h1);
    xfer(1'b1, 32'h6c, 32'h01);
    xfer(1'b0, 32'h6c, 32'h0);
    chk(rd_v, 32'h20);
    xfer(1'b1, 32'h6c, 32'h20);
    tick(2);
    chk(irq, 32'h0);
    // A reset in mid-run must drop live flags and the slew setting.
    overvolt_detect <= 6'h3f;
    @(posedge hclk);
    overvolt_detect <= 6'h00;
    hresetn <= 1'b0;
    tick(3);
    hresetn <= 1'b1;
    tick(2);
    xfer(1'b0, 32'h6c, 32'h0);
    chk(rd_v, 32'h0);
    xfer(1'b0, 32'h7c, 32'h0);
    chk(rd_v, 32'h0);
    chk(ch_auto_skip_enable, 32'h35);
    // An event in the same cycle as its clear must keep the flag.
    overvolt_detect <= 6'h01;
    xfer(1'b1, 32'h6c, 32'h01);
    overvolt_detect <= 6'h00;
    xfer(1'b0, 32'h6c, 32'h0);
    chk(rd_v, 32'h01);
    // Nothing may move while the clock enable is low.
    hclk_en <= 1'b0;
    overvolt_detect <= 6'h3e;
    tick(2);
    overvolt_detect <= 6'h00;
    hclk_en <= 1'b1;
    xfer(1'b0, 32'h6c, 32'h0);
    chk(rd_v, 32'h01);
    wrap_up();
  end
endmodule : pmic_channel_mode_status_regs_tb
